// file: verilog/rst_seq_pkg.sv
package rst_seq_pkg;
    localparam int STARTUP_CYCLES = 1024;
    localparam int STARTUP_W = 11;
    localparam logic [STARTUP_W-1:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [7:0] WDSEL_RESET = 8'h07;
    localparam logic [6:0] IRQ_CTL_RESET = 7'h00;
    localparam logic [7:0] PORT_RESET = 8'hFF;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [2:0] STACK_TOP = 3'h0;
    localparam logic [4:0] TMRC_RESET = 5'h08;

    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_RUN = 4'b0100,
        ST_HALT = 4'b1000
    } seq_state_type;
endpackage

// file: verilog/startup_delay_timer.sv
`timescale 1ns/1ps
module startup_delay_timer
    import rst_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [STARTUP_W-1:0] count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            busy <= 1'b0;
        end else if (ce) begin
            if (start) begin
                count <= '0;
                busy <= 1'b1;
            end else if (busy) begin
                if (count == STARTUP_LAST) begin
                    busy <= 1'b0;
                end
                count <= count + 11'h001;
            end
        end
    end

    assign done = busy && (count == STARTUP_LAST);
endmodule

// file: verilog/mcu_reset_sequencer.sv
`timescale 1ns/1ps
module mcu_reset_sequencer
    import rst_seq_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic halt_entry,
    input wire logic watchdog_clear_instr,
    input wire logic wake_event,
    output logic core_reset,
    output logic fetch_enable,
    output logic halted,
    output logic warm_reset,
    output logic chip_reset,
    output logic pc_clear,
    output logic stack_index_reset,
    output logic watchdog_timer_clear,
    output logic prescaler_clear,
    output logic interrupt_disable,
    output logic timers_off,
    output logic ports_input_mode,
    output logic load_reset_values,
    output logic timeout_flag,
    output logic power_down_flag,
    output logic [12:0] pc_reset_value,
    output logic [2:0] stack_index_value,
    output logic [7:0] bank_select_reg,
    output logic [7:0] watchdog_select_reg,
    output logic [6:0] interrupt_control_reg,
    output logic [7:0] port_data_reset,
    output logic [7:0] port_control_reset,
    output logic [4:0] timer_control_reset
);
    logic rst_meta;
    logic rst_n;
    seq_state_type state;
    seq_state_type next_state;
    logic delay_start;
    logic delay_busy;
    logic delay_done;
    logic pin_low;
    logic full_reset;
    logic warm;

    // Release is synchronised so every flop reset by rst_n leaves reset on the same edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign pin_low = !external_reset_pin_n;
    // Full reset: pin in any state, watchdog only while running
    assign full_reset = pin_low || (watchdog_timeout && state == ST_RUN);
    assign warm = watchdog_timeout && state == ST_HALT && !pin_low;

    always_comb begin
        next_state = state;
        delay_start = 1'b0;
        unique case (state)
            ST_RESET: begin
                if (!pin_low) begin
                    next_state = ST_DELAY;
                    delay_start = 1'b1;
                end
            end
            ST_DELAY: begin
                if (pin_low) begin
                    next_state = ST_RESET;
                end else if (delay_done) begin
                    next_state = ST_RUN;
                end else if (!delay_busy) begin
                    // Idle timer here means a lost start: restart, never skip
                    delay_start = 1'b1;
                end
            end
            ST_RUN: begin
                // Any reset cause outranks halt entry in the same cycle
                if (full_reset) begin
                    // Watchdog has no hold phase, so delay starts at once
                    next_state = pin_low ? ST_RESET : ST_DELAY;
                    delay_start = !pin_low;
                end else if (halt_entry) begin
                    next_state = ST_HALT;
                end
            end
            ST_HALT: begin
                // Pin outranks the watchdog, so a pressed pin never gives a warm reset
                if (pin_low) begin
                    next_state = ST_RESET;
                end else if (warm || wake_event) begin
                    next_state = ST_DELAY;
                    delay_start = 1'b1;
                end
            end
            default: next_state = ST_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RESET;
        end else if (ce) begin
            state <= next_state;
        end
    end

    startup_delay_timer u_startup (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .start(delay_start),
        .busy(delay_busy),
        .done(delay_done)
    );

    // Flags: power-up gives 00 via reset
    // A pin press in a wake delay keeps the flags: halt has already been left
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag <= 1'b0;
            power_down_flag <= 1'b0;
        end else if (ce) begin
            if (state == ST_HALT && pin_low) begin
                timeout_flag <= 1'b0;
                power_down_flag <= 1'b1;
            end else if (warm) begin
                timeout_flag <= 1'b1;
                power_down_flag <= 1'b1;
            end else if (state == ST_RUN && watchdog_timeout && !pin_low) begin
                timeout_flag <= 1'b1;
            end else if (state == ST_RUN && !full_reset) begin
                if (halt_entry) begin
                    power_down_flag <= 1'b1;
                    timeout_flag <= 1'b0;
                end else if (watchdog_clear_instr) begin
                    power_down_flag <= 1'b0;
                end
            end
        end
    end

    // Remembers whether the pending delay follows a full reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_reset <= 1'b1;
        end else if (ce) begin
            if (next_state == ST_RESET || (state == ST_RUN && full_reset)) begin
                chip_reset <= 1'b1;
            end else if (state == ST_DELAY && delay_done) begin
                chip_reset <= 1'b0;
            end
        end
    end

    // One-cycle pulse: state has left HALT by the next edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_reset <= 1'b0;
        end else if (ce) begin
            warm_reset <= warm && !pin_low;
        end
    end

    // Core held through reset and delay of a full reset
    assign core_reset = (state == ST_RESET) || (state == ST_DELAY && chip_reset);
    assign fetch_enable = (state == ST_RUN);
    assign halted = (state == ST_HALT);
    assign pc_clear = core_reset || warm_reset;
    assign stack_index_reset = core_reset || warm_reset;
    assign watchdog_timer_clear = core_reset;
    assign prescaler_clear = core_reset;
    assign interrupt_disable = core_reset;
    assign timers_off = core_reset;
    assign ports_input_mode = core_reset;
    assign load_reset_values = core_reset;

    // Reset values; warm reset never asserts load_reset_values
    // Consumers load these only while load_reset_values is high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reset_value <= PC_RESET;
            stack_index_value <= STACK_TOP;
            bank_select_reg <= BANK_RESET;
            watchdog_select_reg <= WDSEL_RESET;
            interrupt_control_reg <= IRQ_CTL_RESET;
            port_data_reset <= PORT_RESET;
            port_control_reset <= PORT_RESET;
            timer_control_reset <= TMRC_RESET;
        end else if (ce) begin
            pc_reset_value <= PC_RESET;
            stack_index_value <= STACK_TOP;
            bank_select_reg <= BANK_RESET;
            watchdog_select_reg <= WDSEL_RESET;
            interrupt_control_reg <= IRQ_CTL_RESET;
            port_data_reset <= PORT_RESET;
            port_control_reset <= PORT_RESET;
            timer_control_reset <= TMRC_RESET;
        end
    end
endmodule

// file: tb/mcu_reset_sequencer_asserts.sv
`timescale 1ns/1ps
module mcu_reset_sequencer_asserts (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic halt_entry,
    input wire logic core_reset,
    input wire logic fetch_enable,
    input wire logic halted,
    input wire logic warm_reset,
    input wire logic timeout_flag,
    input wire logic power_down_flag,
    input wire logic [7:0] watchdog_select_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [10:0] gap;
    // Saturates so a long pin hold cannot wrap
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap <= 11'h000;
        end else if (fetch_enable || halted) begin
            gap <= 11'h000;
        end else if (gap != 11'h7FF) begin
            gap <= gap + 11'h001;
        end
    end
    property p_pin; ce && !external_reset_pin_n |=> core_reset && !fetch_enable; endproperty
    a_pin: assert property (p_pin) else $error("pin low did not hold core");
    property p_start; $rose(fetch_enable) |-> gap >= 11'h400; endproperty
    a_start: assert property (p_start) else $error("start-up delay too short");
    property p_wd_run;
        ce && external_reset_pin_n && fetch_enable && watchdog_timeout
        |=> core_reset && timeout_flag && power_down_flag == $past(power_down_flag);
    endproperty
    a_wd_run: assert property (p_wd_run) else $error("running timeout wrong");
    property p_warm;
        ce && external_reset_pin_n && halted && watchdog_timeout
        |=> warm_reset && !core_reset && timeout_flag && power_down_flag;
    endproperty
    a_warm: assert property (p_warm) else $error("warm reset wrong");
    property p_warm_len; warm_reset |=> !warm_reset; endproperty
    a_warm_len: assert property (p_warm_len) else $error("warm pulse too long");
    property p_halt;
        ce && external_reset_pin_n && fetch_enable && halt_entry && !watchdog_timeout
        |=> halted && power_down_flag && !timeout_flag;
    endproperty
    a_halt: assert property (p_halt) else $error("halt entry flags wrong");
    property p_pin_halt; ce && !external_reset_pin_n && halted |=> power_down_flag && !timeout_flag;
    endproperty
    a_pin_halt: assert property (p_pin_halt) else $error("halt pin flags wrong");
    property p_vals; core_reset |-> watchdog_select_reg == 8'h07; endproperty
    a_vals: assert property (p_vals) else $error("select reset value wrong");
endmodule

// file: tb/reset_pin_board.sv
`timescale 1ns/1ps
module reset_pin_board (
    input wire logic clk,
    output logic external_reset_pin_n
);
    initial external_reset_pin_n = 1'b1;
    // Pull-up brings the pin back high on release
    task automatic press(input int cycles);
        @(negedge clk);
        external_reset_pin_n = 1'b0;
        repeat (cycles) @(negedge clk);
        external_reset_pin_n = 1'b1;
    endtask
endmodule

// file: tb/mcu_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
module mcu_reset_sequencer_tb_top;
    import rst_seq_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] pulse = 4'h0;
    logic pin_n, core_reset, fetch_enable, halted, warm_reset, timeout_flag, power_down_flag;
    logic [7:0] watchdog_select_reg, bank_select_reg, port_data_reset, port_ctl;
    wire [8:0] ctl;
    logic [12:0] pc_val;
    logic [2:0] stack_val;
    logic [6:0] irq_ctl;
    logic [4:0] tmr_ctl;
    logic [1:0] old;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 39825;
    int n;
    always #20 clk = ~clk;
    reset_pin_board board (.clk(clk), .external_reset_pin_n(pin_n));
    mcu_reset_sequencer dut (.clk(clk), .arst_n(arst_n), .ce(ce), .external_reset_pin_n(pin_n),
        .watchdog_timeout(pulse[0]), .halt_entry(pulse[1]), .watchdog_clear_instr(pulse[2]),
        .wake_event(pulse[3]), .core_reset(core_reset), .fetch_enable(fetch_enable),
        .halted(halted), .warm_reset(warm_reset), .chip_reset(ctl[8]), .pc_clear(ctl[0]),
        .stack_index_reset(ctl[1]), .watchdog_timer_clear(ctl[2]), .prescaler_clear(ctl[3]),
        .interrupt_disable(ctl[4]), .timers_off(ctl[5]), .ports_input_mode(ctl[6]),
        .load_reset_values(ctl[7]), .timeout_flag(timeout_flag),
        .power_down_flag(power_down_flag), .pc_reset_value(pc_val),
        .stack_index_value(stack_val), .bank_select_reg(bank_select_reg),
        .watchdog_select_reg(watchdog_select_reg), .interrupt_control_reg(irq_ctl),
        .port_data_reset(port_data_reset), .port_control_reset(port_ctl),
        .timer_control_reset(tmr_ctl));
    function automatic logic [1:0] exp_flags(input int cause, input logic [1:0] prev);
        case (cause)
            0: return prev;
            1: return 2'b01;
            2: return {1'b1, prev[0]};
            default: return 2'b11;
        endcase
    endfunction
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic fire(input int i);
        @(negedge clk);
        pulse[i] = 1'b1;
        @(negedge clk);
        pulse = 4'h0;
    endtask
    task automatic settle();
        n = 0;
        while (fetch_enable !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk(n > 1021 && n < 1032, "start-up delay length");
    endtask
    initial begin
        #(40 * 20000);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        settle();
        chk({timeout_flag, power_down_flag} === 2'b00, "power-up flags");
        chk({bank_select_reg, port_data_reset} === 16'h00FF, "reset values");
        chk(ctl === 9'h000 && pc_val === 13'h0000 && stack_val === 3'h0,
            "run outputs");
        chk(irq_ctl === 7'h00 && port_ctl === 8'hFF && tmr_ctl === 5'h08
            && watchdog_select_reg === 8'h07, "other reset values");
        fire(0);
        chk(core_reset === 1'b1 && {timeout_flag, power_down_flag} === exp_flags(2, 2'b00),
            "run timeout");
        chk(ctl === 9'h1FF, "full reset controls");
        settle();
        fire(1);
        chk(halted === 1'b1 && {timeout_flag, power_down_flag} === 2'b01, "halt");
        fire(3);
        chk(halted === 1'b0 && core_reset === 1'b0 && fetch_enable === 1'b0, "wake");
        settle();
        fire(0);
        chk({timeout_flag, power_down_flag} === exp_flags(2, 2'b01), "run timeout pdf");
        settle();
        fire(1);
        fire(0);
        chk(warm_reset === 1'b1 && core_reset === 1'b0
            && {timeout_flag, power_down_flag} === exp_flags(3, 2'b01), "warm");
        chk(ctl === 9'h003, "warm reset controls");
        @(negedge clk);
        chk(warm_reset === 1'b0, "warm pulse");
        settle();
        for (int k = 0; k < 2; k++) begin
            old = {timeout_flag, power_down_flag};
            if (k == 1) fire(1);
            board.press(2 + int'($unsigned($random(seed)) % 6));
            chk(core_reset === 1'b1 && {timeout_flag, power_down_flag} === exp_flags(k, old),
                "pin reset");
            settle();
        end
        ce = 1'b0;
        fire(1);
        chk(halted === 1'b0 && {timeout_flag, power_down_flag} === 2'b01, "frozen");
        ce = 1'b1;
        fire(2);
        chk(power_down_flag === 1'b0, "clear instruction");
        stop_test();
    end
endmodule
bind mcu_reset_sequencer mcu_reset_sequencer_asserts chk_i (.clk(clk), .arst_n(arst_n),
    .ce(ce), .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .halt_entry(halt_entry), .core_reset(core_reset), .fetch_enable(fetch_enable),
    .halted(halted), .warm_reset(warm_reset), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag), .watchdog_select_reg(watchdog_select_reg));
